// file: gpio_remap_defines.svh
`ifndef GPIO_REMAP_DEFINES_SVH
`define GPIO_REMAP_DEFINES_SVH
// base register word offsets, aliases at +4 clear, +8 set, +c invert
`define OFS_DIR 12'h000
`define OFS_ANSEL 12'h010
`define OFS_LATCH 12'h020
`define OFS_PORT 12'h030
`define OFS_CNEN 12'h040
`define OFS_CNSTAT 12'h050
`define OFS_PULLUP 12'h060
`define OFS_PULLDN 12'h070
`define OFS_CNCON 12'h080
`define OFS_LOCK 12'h090
`define OFS_SEL_BASE 12'h100
// field positions
`define CNCON_ON_BIT 15
`define LOCK_BIT 0
`define SEL_MSB 3
// reset values (dir and ansel per bit, replicated over the port; sel per selector; one-way single)
`define RST_DIR_BIT 1'b1
`define RST_ANSEL_BIT 1'b1
`define RST_SEL 4'ha
`define RST_ONE_WAY 1'b1
// selector code to pin map: {present, pin[3:0]} for codes 15..0
`define RP_MAP_DEFAULT {5'h00, 5'h00, 5'h1d, 5'h1c, 5'h1b, 5'h00, 5'h19, 5'h18, \
  5'h17, 5'h16, 5'h15, 5'h00, 5'h13, 5'h12, 5'h11, 5'h10}
`endif

// file: gpio_remap_pkg.sv
package gpio_remap_pkg;
  // operation selected by address bits 3:2 of a base register
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CLEAR = 2'h1,
    OP_SET = 2'h2,
    OP_INVERT = 2'h3
  } alias_op_t;
  // selector code type
  typedef logic [3:0] sel_code_t;
endpackage

// file: change_detect.sv
`timescale 1ns/1ps
module change_detect #(
  parameter int NPIN = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [NPIN-1:0] pin_now,
  input wire logic ack,
  output logic [NPIN-1:0] status
);
  // reference level, previous sample, sticky status
  typedef struct packed {
    logic [NPIN-1:0] ref_lvl;
    logic [NPIN-1:0] prev;
    logic [NPIN-1:0] stat;
  } cd_state_t;
  cd_state_t s_reg, s_next;

  // refuse an empty port
  if (NPIN < 1) begin : g_chk
    $error("change_detect: NPIN must be at least 1");
  end

  // a port read re-arms the reference; a change in that cycle still sets
  always_comb begin
    s_next = s_reg;
    s_next.prev = pin_now;
    if (ack) begin
      s_next.ref_lvl = pin_now;
      s_next.stat = enable ? (pin_now ^ s_reg.prev) : '0;
    end else if (enable) begin
      s_next.stat = s_reg.stat | (pin_now ^ s_reg.ref_lvl);
    end else begin
      // while detection is off the reference follows the pins, so switching on flags nothing stale
      s_next.ref_lvl = pin_now;
    end
  end

  // register the state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign status = s_reg.stat;
endmodule // change_detect

// file: remap_in_mux.sv
`timescale 1ns/1ps
`include "gpio_remap_defines.svh"
module remap_in_mux #(
  parameter int NIN = 39,
  parameter int NPIN = 16,
  parameter logic [79:0] RP_MAP = `RP_MAP_DEFAULT,
  parameter logic [NIN-1:0] IDLE = '1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic [5:0] widx,
  input wire gpio_remap_pkg::sel_code_t wcode,
  input wire logic locked,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic [NPIN-1:0] pin_analog,
  output logic [NIN*4-1:0] sel_flat,
  output logic [NIN-1:0] periph_in
);
  import gpio_remap_pkg::*;
  // selector store and registered peripheral inputs
  typedef struct packed {
    logic [NIN-1:0][3:0] sel;
    logic [NIN-1:0] pin_q;
  } rm_state_t;
  rm_state_t s_reg, s_next;

  // selector index must fit six bits and pin index four
  if (NIN < 1 || NIN > 64 || NPIN < 1 || NPIN > 16) begin : g_chk
    $error("remap_in_mux: NIN or NPIN out of range");
  end

  // decode a selector code to {present, pin index}
  function automatic logic [4:0] pick(input sel_code_t code);
    pick = RP_MAP[code*5 +: 5];
  endfunction

  // one selector per peripheral input
  always_comb begin
    s_next = s_reg;
    for (int i = 0; i < NIN; i++) begin
      logic [4:0] m;
      m = pick(s_reg.sel[i]);
      // absent pins and analog pins leave the input idle
      if (m[4] && !pin_analog[m[3:0]]) begin
        s_next.pin_q[i] = pad_in[m[3:0]];
      end else begin
        s_next.pin_q[i] = IDLE[i];
      end
    end
    // locked writes complete but change nothing
    if (we && !locked && 32'(widx) < NIN) begin
      s_next.sel[widx] = wcode;
    end
  end

  // register the state; selectors start unassigned
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg.sel <= {NIN{`RST_SEL}};
      s_reg.pin_q <= IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sel_flat = s_reg.sel;
  assign periph_in = s_reg.pin_q;
endmodule // remap_in_mux

// file: gpio_remap_port.sv
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "gpio_remap_defines.svh"
module gpio_remap_port #(
  parameter int NPIN = 16,
  parameter int NIN = 39,
  parameter logic [79:0] RP_MAP = `RP_MAP_DEFAULT,
  parameter logic [NIN-1:0] IN_IDLE = '1
) (
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // pad side
  input wire logic [NPIN-1:0] pad_in,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe_n,
  output logic [NPIN-1:0] pad_pu_en,
  output logic [NPIN-1:0] pad_pd_en,
  output logic [NPIN-1:0] analog_conn,
  // fixed-pin peripherals driving their default pins
  input wire logic [NPIN-1:0] fixed_drive_en,
  input wire logic [NPIN-1:0] fixed_drive_val,
  // remapped peripheral outputs from the output map
  input wire logic [NPIN-1:0] rp_drive_en,
  input wire logic [NPIN-1:0] rp_drive_val,
  // remapped peripheral inputs, one per selector
  output logic [NIN-1:0] periph_in,
  // configuration strap and events
  input wire logic lock_one_way_strap,
  output logic change_irq,
  output logic remap_locked
);
  import gpio_remap_pkg::*;

  // all register and pin state of the port apart from the selectors, registered peripheral inputs and change status
  typedef struct packed {
    logic [NPIN-1:0] dir;       // 1 = input
    logic [NPIN-1:0] ansel;     // 1 = analog
    logic [NPIN-1:0] lat;       // output latch
    logic [NPIN-1:0] cnen;      // change enables
    logic [NPIN-1:0] pu;        // pull-up enables
    logic [NPIN-1:0] pd;        // pull-down enables
    logic cn_on;                // change detection on
    logic lock;                 // remap lock
    logic one_way;              // captured strap
    logic strap_done;           // strap already taken
    logic [31:0] rd;            // read data
    logic [NPIN-1:0] pout;      // pad level
    logic [NPIN-1:0] poe_n;     // pad enable, low drives
    logic [NPIN-1:0] ppu;       // pad pull-up
    logic [NPIN-1:0] ppd;       // pad pull-down
    logic [NPIN-1:0] pana;      // analog path
    logic irq;                  // change interrupt
  } port_state_t;
  port_state_t s_reg, s_next;

  // submodule results
  logic [NPIN-1:0] cn_status;
  logic [NIN*4-1:0] sel_flat;
  // decoded access
  alias_op_t op;
  logic [7:0] base_idx;
  logic sel_hit;
  logic [5:0] sel_idx;
  logic port_ack;
  logic [NPIN-1:0] port_view;

  // only sixteen-bit-or-less ports fit the register words
  if (NPIN < 1 || NPIN > 16 || NIN < 1 || NIN > 64) begin : g_chk
    $error("gpio_remap_port: NPIN or NIN out of range");
  end

  // apply a plain write or an alias to a base value
  function automatic logic [NPIN-1:0] apply_op(
    input logic [NPIN-1:0] cur,
    input logic [NPIN-1:0] w,
    input alias_op_t o
  );
    unique case (o)
      OP_WRITE: apply_op = w;
      OP_CLEAR: apply_op = cur & ~w;
      OP_SET: apply_op = cur | w;
      OP_INVERT: apply_op = cur ^ w;
    endcase
  endfunction

  // does the access hit a given base register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:4] == ofs[11:4]);
  endfunction

  // address decode shared by reads and writes
  always_comb begin
    op = alias_op_t'(addr[3:2]);
    base_idx = addr[11:4];
    // only the implemented selector words count; higher addresses are unmapped
    sel_hit = (addr >= `OFS_SEL_BASE) && ((addr - `OFS_SEL_BASE) < 12'(4 * NIN));
    sel_idx = 6'((addr - `OFS_SEL_BASE) >> 2);
  end

  // port view: analog inputs read as zero
  assign port_view = pad_in & ~(s_reg.ansel & s_reg.dir);
  // a plain read of the port re-arms change status
  assign port_ack = rd_en && hit(addr, `OFS_PORT) && op == OP_WRITE;

  // change status per pin
  change_detect #(
    .NPIN(NPIN)
  ) u_change (
    .mclk(mclk),
    .rst(rst),
    .enable(s_reg.cn_on),
    .pin_now(pad_in),
    .ack(port_ack),
    .status(cn_status)
  );

  // peripheral input selection
  remap_in_mux #(
    .NIN(NIN),
    .NPIN(NPIN),
    .RP_MAP(RP_MAP),
    .IDLE(IN_IDLE)
  ) u_remap (
    .mclk(mclk),
    .rst(rst),
    .we(wr_en && sel_hit),
    .widx(sel_idx),
    .wcode(wdata[`SEL_MSB:0]),
    .locked(s_reg.lock),
    .pad_in(pad_in),
    .pin_analog(s_reg.ansel),
    .sel_flat(sel_flat),
    .periph_in(periph_in)
  );

  // next state of registers, read data and pads
  always_comb begin
    logic [NPIN-1:0] w;
    logic [NPIN-1:0] rp_act;
    logic [NPIN-1:0] fx_act;
    logic [NPIN-1:0] lk;
    w = wdata[NPIN-1:0];
    rp_act = '0;
    fx_act = '0;
    lk = '0;
    s_next = s_reg;

    // take the one-way strap once after reset
    if (!s_reg.strap_done) begin
      s_next.one_way = lock_one_way_strap;
      s_next.strap_done = 1'b1;
    end

    // register writes, each base with its aliases
    if (wr_en && !sel_hit) begin
      unique case (base_idx)
        `OFS_DIR >> 4: s_next.dir = apply_op(s_reg.dir, w, op);
        `OFS_ANSEL >> 4: s_next.ansel = apply_op(s_reg.ansel, w, op);
        // port writes land in the latch
        `OFS_LATCH >> 4, `OFS_PORT >> 4: s_next.lat = apply_op(s_reg.lat, w, op);
        `OFS_CNEN >> 4: s_next.cnen = apply_op(s_reg.cnen, w, op);
        `OFS_PULLUP >> 4: s_next.pu = apply_op(s_reg.pu, w, op);
        `OFS_PULLDN >> 4: s_next.pd = apply_op(s_reg.pd, w, op);
        `OFS_CNCON >> 4: begin
          lk = apply_op({NPIN{s_reg.cn_on}}, {NPIN{wdata[`CNCON_ON_BIT]}}, op);
          s_next.cn_on = lk[0];
        end
        `OFS_LOCK >> 4: begin
          lk = apply_op({NPIN{s_reg.lock}}, {NPIN{wdata[`LOCK_BIT]}}, op);
          // one-way lock cannot be released once set
          s_next.lock = lk[0] | (s_reg.lock & s_reg.one_way);
        end
        // status register is read only; others unmapped
        default: begin
        end
      endcase
    end

    // read data, alias reads give zero
    s_next.rd = '0;
    if (rd_en) begin
      if (sel_hit) begin
        if (32'(sel_idx) < NIN && addr[1:0] == 2'h0) begin
          s_next.rd = {28'h0, sel_flat[sel_idx*4 +: 4]};
        end
      end else if (op == OP_WRITE) begin
        unique case (base_idx)
          `OFS_DIR >> 4: s_next.rd[NPIN-1:0] = s_reg.dir;
          `OFS_ANSEL >> 4: s_next.rd[NPIN-1:0] = s_reg.ansel;
          `OFS_LATCH >> 4: s_next.rd[NPIN-1:0] = s_reg.lat;
          // pads reflect a new drive one cycle after the write
          `OFS_PORT >> 4: s_next.rd[NPIN-1:0] = port_view;
          `OFS_CNEN >> 4: s_next.rd[NPIN-1:0] = s_reg.cnen;
          `OFS_CNSTAT >> 4: s_next.rd[NPIN-1:0] = cn_status;
          `OFS_PULLUP >> 4: s_next.rd[NPIN-1:0] = s_reg.pu;
          `OFS_PULLDN >> 4: s_next.rd[NPIN-1:0] = s_reg.pd;
          `OFS_CNCON >> 4: s_next.rd[`CNCON_ON_BIT] = s_reg.cn_on;
          `OFS_LOCK >> 4: s_next.rd[`LOCK_BIT] = s_reg.lock;
          // unmapped reads give zero
          default: begin
          end
        endcase
      end
    end

    // pad ownership: analog, then remapped, then fixed, then latch
    rp_act = rp_drive_en & ~s_reg.ansel;
    fx_act = fixed_drive_en & ~s_reg.ansel & ~rp_act;
    for (int i = 0; i < NPIN; i++) begin
      if (s_reg.ansel[i]) begin
        // analog pin set as output still drives its latch
        s_next.pout[i] = s_reg.lat[i];
        s_next.poe_n[i] = s_reg.dir[i];
      end else if (rp_act[i]) begin
        s_next.pout[i] = rp_drive_val[i];
        s_next.poe_n[i] = 1'b0;
      end else if (fx_act[i]) begin
        s_next.pout[i] = fixed_drive_val[i];
        s_next.poe_n[i] = 1'b0;
      end else begin
        s_next.pout[i] = s_reg.lat[i];
        s_next.poe_n[i] = s_reg.dir[i];
      end
    end
    // pulls follow their enables; keeping them off on outputs is software's job
    s_next.ppu = s_reg.pu;
    s_next.ppd = s_reg.pd;
    s_next.pana = s_reg.ansel;

    // change interrupt from enabled pins, logic stays on the always-on clock
    s_next.irq = s_reg.cn_on && |(cn_status & s_reg.cnen);
  end

  // register the whole state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.dir <= {NPIN{`RST_DIR_BIT}};
      s_reg.ansel <= {NPIN{`RST_ANSEL_BIT}};
      s_reg.one_way <= `RST_ONE_WAY;
      s_reg.poe_n <= {NPIN{`RST_DIR_BIT}};
      s_reg.pana <= {NPIN{`RST_ANSEL_BIT}};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign rdata = s_reg.rd;
  assign pad_out = s_reg.pout;
  assign pad_oe_n = s_reg.poe_n;
  assign pad_pu_en = s_reg.ppu;
  assign pad_pd_en = s_reg.ppd;
  assign analog_conn = s_reg.pana;
  assign change_irq = s_reg.irq;
  assign remap_locked = s_reg.lock;
endmodule // gpio_remap_port

// file: gpio_port_props.sv
`timescale 1ns/1ps
// protocol and pin checks on the port's boundary
module gpio_port_props #(
  parameter int NPIN = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic [NPIN-1:0] pad_out,
  input wire logic [NPIN-1:0] pad_oe_n,
  input wire logic [NPIN-1:0] pad_pu_en,
  input wire logic [NPIN-1:0] pad_pd_en,
  input wire logic [NPIN-1:0] analog_conn,
  input wire logic [NPIN-1:0] rp_drive_en,
  input wire logic [NPIN-1:0] rp_drive_val,
  input wire logic lock_one_way_strap,
  input wire logic change_irq,
  input wire logic remap_locked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rdata_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata set without read");
  property p_alias_rd; rd_en && addr < 12'h100 && addr[3:2] != 2'h0 |=> rdata == 32'h0; endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read not zero");
  property p_port_analog;
    rd_en && addr == 12'h030 |=> (rdata[NPIN-1:0] & analog_conn & pad_oe_n) == '0;
  endproperty
  a_port_analog: assert property (p_port_analog) else $error("analog input read as one");
  property p_pull_wr;
    $changed(pad_pu_en) || $changed(pad_pd_en) |-> $past(wr_en, 2) || $past(rst, 2);
  endproperty
  a_pull_wr: assert property (p_pull_wr) else $error("pull changed without write");
  property p_lock_rise;
    $rose(remap_locked) |-> ($past(wr_en) && $past(addr[11:4]) == 8'h09) ||
      ($past(wr_en, 2) && $past(addr[11:4], 2) == 8'h09);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock set without write");
  property p_lock_hold; remap_locked && lock_one_way_strap |=> remap_locked; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("one-way lock cleared");
  property p_rst_vals; $fell(rst) |-> pad_oe_n == '1 && analog_conn == '1 && !change_irq; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");
  property p_remap_wins;
    ((pad_out ^ $past(rp_drive_val)) & $past(rp_drive_en) & ~analog_conn & ~pad_oe_n) == '0;
  endproperty
  a_remap_wins: assert property (p_remap_wins) else $error("remapped drive lost");
  property p_irq_cause;
    $rose(change_irq) |-> $past(pad_in, 2) != $past(pad_in, 3) || $past(wr_en) || $past(wr_en, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without pin change");
  c_lock: cover property (wr_en && addr == 12'h090);
  c_irq: cover property ($rose(change_irq));
  c_port: cover property (rd_en && addr == 12'h030);
endmodule // gpio_port_props

// file: pin_world.sv
`timescale 1ns/1ps
// board side of the pads: external drivers, pulls and wandering open lines
module pin_world (
  input wire logic mclk,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe_n,
  input wire logic [15:0] pad_pu_en,
  input wire logic [15:0] pad_pd_en,
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  output logic [15:0] pad_in
);
  logic [15:0] float_pat = 16'h5555; // open line flips every cycle
  always_ff @(posedge mclk) begin
    float_pat <= ~float_pat;
  end
  // device drive first, then board driver, then weak pulls
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pu_en[i]) pad_in[i] = 1'b1;
      else if (pad_pd_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = float_pat[i];
    end
  end
endmodule // pin_world

// file: tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata, rv;
  logic [15:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en, analog_conn;
  logic [15:0] fix_en = 16'h0, fix_val = 16'h0, rp_en = 16'h0, rp_val = 16'h0;
  logic [15:0] ext_en = 16'hffff, ext_val = 16'hffff;
  logic [38:0] periph_in;
  logic change_irq, remap_locked;
  int bad_count = 0;
  int check_count = 0;
  row_t rows [10] = '{
    '{12'h020, 32'h00ff, 12'h020, 32'h00ff}, '{12'h028, 32'h0f00, 12'h020, 32'h0fff},
    '{12'h024, 32'h00f0, 12'h020, 32'h0f0f}, '{12'h02c, 32'hffff, 12'h020, 32'hf0f0},
    '{12'h068, 32'h0003, 12'h060, 32'h0003}, '{12'h070, 32'h0004, 12'h070, 32'h0004},
    '{12'h104, 32'h0007, 12'h104, 32'h0007}, '{12'h050, 32'hffff, 12'h050, 32'h0},
    '{12'h01c, 32'h0, 12'h018, 32'h0}, '{12'h800, 32'hffff, 12'h800, 32'h0}};
  always #2 mclk = ~mclk;
  gpio_remap_port dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en),
    .pad_pd_en(pad_pd_en), .analog_conn(analog_conn), .fixed_drive_en(fix_en), .fixed_drive_val(fix_val),
    .rp_drive_en(rp_en), .rp_drive_val(rp_val), .periph_in(periph_in), .lock_one_way_strap(1'b1),
    .change_irq(change_irq), .remap_locked(remap_locked));
  pin_world pins_u (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en),
    .pad_pd_en(pad_pd_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // read strobe, data taken in the following cycle
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // watchdog against a hung sequence
  initial begin
    #20000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("oe_n", 32'hffff, 32'(pad_oe_n));
    chk("aconn", 32'hffff, 32'(analog_conn));
    chk("pin", 32'hffffffff, periph_in[31:0]);
    rdc("dir", 12'h000, 32'hffff);
    rdc("ansel", 12'h010, 32'hffff);
    rdc("sel", 12'h100, 32'ha);
    for (int i = 0; i < 10; i++) begin
      wr(rows[i].wa, rows[i].wd);
      rdc("row", rows[i].ra, rows[i].ex);
    end
    @(posedge mclk) ext_en <= 16'hfdfb;
    wr(12'h068, 32'h0200);
    wr(12'h014, 32'hffff);
    idle(1);
    chk("pu", 32'h0203, 32'(pad_pu_en));
    rdc("pull", 12'h030, 32'hfffb);
    wr(12'h064, 32'hffff);
    wr(12'h074, 32'hffff);
    @(posedge mclk) ext_en <= 16'hffff;
    wr(12'h018, 32'h00ff);
    rdc("port", 12'h030, 32'hff00);
    wr(12'h004, 32'h1);
    wr(12'h028, 32'h1);
    idle(2);
    chk("aout", 32'h1, 32'({pad_oe_n[0], pad_out[0]}));
    rdc("port", 12'h030, 32'hff01);
    wr(12'h010, 32'h0);
    wr(12'h008, 32'h1);
    for (int c = 0; c < 16; c++) begin
      @(posedge mclk) ext_val <= 16'hffff ^ (16'h1 << c);
      wr(12'h100, 32'(c));
      idle(2);
      chk("code", 32'(c == 4 || c == 10 || c == 14 || c == 15), 32'(periph_in[0]));
    end
    wr(12'h100, 32'h3);
    @(posedge mclk) ext_val <= 16'hfff7;
    wr(12'h018, 32'h8);
    idle(2);
    chk("ana in", 32'h1, 32'(periph_in[0]));
    wr(12'h014, 32'h8);
    wr(12'h004, 32'h20);
    @(posedge mclk) ext_val <= 16'hffff;
    fix_en <= 16'h0020;
    rp_en <= 16'h0020;
    rp_val <= 16'h0020;
    idle(2);
    chk("remap", 32'h1, 32'(pad_out[5]));
    @(posedge mclk) rp_en <= 16'h0;
    idle(2);
    chk("fixed", 32'h0, 32'(pad_out[5]));
    wr(12'h018, 32'h20);
    @(posedge mclk) rp_en <= 16'h0020;
    rp_val <= 16'h0;
    idle(2);
    chk("ana out", 32'h1, 32'(pad_out[5]));
    @(posedge mclk) rp_en <= 16'h0;
    fix_en <= 16'h0;
    wr(12'h014, 32'h20);
    wr(12'h008, 32'h20);
    wr(12'h040, 32'h80);
    wr(12'h080, 32'h8000);
    rdc("port", 12'h030, 32'hffff);
    @(posedge mclk) ext_val <= 16'hffbf;
    idle(3);
    chk("irq off", 32'h0, 32'(change_irq));
    @(posedge mclk) ext_val <= 16'hff3f;
    idle(3);
    chk("irq on", 32'h1, 32'(change_irq));
    rdc("stat", 12'h050, 32'hc0);
    rdc("port", 12'h030, 32'hff3f);
    rdc("stat", 12'h050, 32'h0);
    idle(2);
    chk("irq clr", 32'h0, 32'(change_irq));
    wr(12'h100, 32'h1);
    wr(12'h090, 32'h1);
    wr(12'h100, 32'h2);
    rdc("locked", 12'h100, 32'h1);
    wr(12'h094, 32'h1);
    idle(1);
    chk("lock", 32'h1, 32'(remap_locked));
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk("unlock", 32'h0, 32'(remap_locked));
    rdc("sel", 12'h100, 32'ha);
    final_report();
  end
endmodule // tb
bind gpio_remap_port gpio_port_props #(.NPIN(NPIN)) props_u (.mclk(mclk), .rst(rst), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
  .pad_pu_en(pad_pu_en), .pad_pd_en(pad_pd_en), .analog_conn(analog_conn), .rp_drive_en(rp_drive_en),
  .rp_drive_val(rp_drive_val), .lock_one_way_strap(lock_one_way_strap), .change_irq(change_irq),
  .remap_locked(remap_locked));
